// [logic/cwl_pkg.sv]
// Functional notes
// - Programmed bit reads 0, unprogrammed reads 1
// - Unpacked config bits mapped from F80000h
// - Config space reachable by table access only
// - Config registers volatile, reloaded after power-up
// - Three packed words at flash top
// - Loader unpacks words once device reset is released
// - Reload happens on every reset type
// - Erasing last page disables code protection
// - Bit 14 enables test port
// - Bit 13 low enables code protection
// - Bit 12 low blocks program writes
// - Bit 11 picks operational or debug reset
// - Bits 9-8 pick emulator pin pair
// - Bit 7 enables watchdog
// - Bit 6 low selects windowed watchdog
// - Bit 4 selects prescaler 128 or 32
// - Bits 3-0 select postscaler power of two
`default_nettype none
package cwl_pkg;
   localparam int unsigned ADDR_W      = 24;                    // Program address width
   localparam int unsigned WORD_W      = 24;                    // Flash word width
   localparam int unsigned NUM_WORDS   = 3;                     // Packed configuration words
   localparam logic [23:0] CFG_TOP_SMALL = 24'h00ABFE;          // Word one, smallest density
   localparam logic [23:0] CFG_TOP_LARGE = 24'h02ABFE;          // Word one, largest density
   localparam logic [23:0] CFG_STEP    = 24'h000002;            // Address step between words
   localparam logic [23:0] CFG_SPACE_LO = 24'h800000;           // Configuration space base
   localparam logic [23:0] CFG_MAP_BASE = 24'hF80000;           // Unpacked bits base
   localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;            // Unprogrammed state
   localparam logic [23:0] ZERO_WORD   = 24'h000000;            // Idle read value
   localparam logic [1:0]  IDX_W1      = 2'h0;                  // Word one slot
   localparam logic [1:0]  IDX_W2      = 2'h1;                  // Word two slot
   localparam logic [1:0]  IDX_W3      = 2'h2;                  // Word three slot
   localparam logic [1:0]  IDX_LAST    = 2'h2;                  // Final slot
   localparam int unsigned B_TEST      = 14;                    // Test port enable
   localparam int unsigned B_CODE_PROT = 13;                    // Code protect, active low
   localparam int unsigned B_GWP       = 12;                    // Write protect, active low
   localparam int unsigned B_OPER      = 11;                    // Operational mode select
   localparam int unsigned B_EMU_HI    = 9;                     // Pin pair select high
   localparam int unsigned B_EMU_LO    = 8;                     // Pin pair select low
   localparam int unsigned B_WDT_EN    = 7;                     // Watchdog enable
   localparam int unsigned B_WIN_DIS   = 6;                     // Window disable
   localparam int unsigned B_PRE       = 4;                     // Prescaler select
   localparam int unsigned B_POST_HI   = 3;                     // Postscaler high bit
   localparam logic [1:0]  PAIR_ONE    = 2'h3;                  // Pin pair 1
   localparam logic [1:0]  PAIR_TWO    = 2'h2;                  // Pin pair 2
   localparam logic [1:0]  PAIR_THREE  = 2'h1;                  // Pin pair 3
   localparam logic [1:0]  PAIR_RSVD   = 2'h0;                  // Reserved pair code
   localparam logic [7:0]  PRE_128     = 8'h80;                 // Ratio 1:128
   localparam logic [7:0]  PRE_32      = 8'h20;                 // Ratio 1:32

   // Loader sequence, Gray coded along the path
   typedef enum logic [2:0] {
      CWL_REQ  = 3'h0,
      CWL_WAIT = 3'h1,
      CWL_DONE = 3'h3
   } cwl_state_e;

   // Decoded word-one controls
   typedef struct packed {
      logic        test_port_enable;          // Boundary-scan port on
      logic        code_protect_on;           // Whole memory read-protected
      logic        write_protect_on;          // Program writes blocked
      logic        debug_mode_entry;          // Reset into debug mode
      logic [1:0]  emulator_pin_pair_select;  // Raw pair code
      logic        watchdog_enable;           // Watchdog running
      logic        window_mode;               // Windowed watchdog
      logic [7:0]  prescale_ratio;            // 32 or 128
      logic [15:0] postscale_ratio;           // 1 .. 32768
   } cwl_ctrl_s;

   // Table access request
   typedef struct packed {
      logic                 rd;               // Table read
      logic                 wr;               // Table write
      logic [ADDR_W-1:0]    addr;             // Table address
   } cwl_tbl_s;

   // Whole module state
   typedef struct packed {
      cwl_state_e           st;
      logic [1:0]           idx;
      logic [WORD_W-1:0]    w1;
      logic [WORD_W-1:0]    w2;
      logic [WORD_W-1:0]    w3;
      logic [WORD_W-1:0]    rdata;
      logic                 rvalid;
   } cwl_regs_s;
endpackage : cwl_pkg
`default_nettype wire

// [logic/cwl_loader.sv]
`timescale 1ns/1ps
`default_nettype none
module cwl_loader
   import cwl_pkg::*;
#(
   parameter logic [23:0] CFG_TOP = CFG_TOP_LARGE              // Density-dependent top word
) (
   input  wire logic              sys_clk,         // 200 MHz system clock
   input  wire logic              reset_n,         // Any device reset, active low
   output logic                   flash_rd,        // Flash read strobe
   output logic [ADDR_W-1:0]      flash_addr,      // Flash read address
   input  wire logic              flash_ack,       // Flash data valid
   input  wire logic [WORD_W-1:0] flash_rdata,     // Flash read data
   input  wire cwl_tbl_s          tbl_req,         // Table access request
   input  wire logic              fetch_rd,        // Ordinary data or fetch read
   input  wire logic [ADDR_W-1:0] fetch_addr,      // Ordinary access address
   output logic [WORD_W-1:0]      tbl_rdata,       // Table read data
   output logic                   tbl_rvalid,      // Table read data valid
   output logic                   fetch_blocked,   // Ordinary access hit config space
   output logic                   cfg_loaded,      // Configuration valid
   output cwl_ctrl_s              ctrl,            // Decoded controls
   output logic                   pair_reserved    // Reserved pair code loaded
);

   // Address of the n-th packed word, stepping down from the top
   // Word one sits highest so the block works for any density: only the
   // top address parameter moves, the downward step stays the same
   function automatic logic [ADDR_W-1:0] word_addr(input logic [1:0] n);
      logic [ADDR_W-1:0] step;
      step = CFG_STEP * {22'h0, n};
      return CFG_TOP - step;
   endfunction : word_addr

   // Configuration space membership
   // Shared by table reads and fetch blocking so both agree on the boundary
   function automatic logic in_cfg(input logic [ADDR_W-1:0] a);
      return a >= CFG_SPACE_LO;
   endfunction : in_cfg

   // All loader state lives in one struct: one flop bank, one next-state copy,
   // so a reset cannot leave a field behind
   cwl_regs_s r_ff;       // Registered state
   cwl_regs_s nxt_r;      // Next state

   // Loader and table read port
   // Each word costs one request cycle plus the flash latency; the extra
   // request cycle drops the read strobe between words so the flash side
   // sees a fresh access for every address
   always_comb begin
      nxt_r        = r_ff;
      nxt_r.rvalid = 1'b0;
      unique case (r_ff.st)
         CWL_REQ: begin
            nxt_r.st = CWL_WAIT;
         end
         CWL_WAIT: begin
            if (flash_ack) begin
               // Store word by slot; ignore upper byte of w1 decode
               if (r_ff.idx == IDX_W1) begin
                  nxt_r.w1 = flash_rdata;
               end else if (r_ff.idx == IDX_W2) begin
                  nxt_r.w2 = flash_rdata;
               end else begin
                  nxt_r.w3 = flash_rdata;
               end
               if (r_ff.idx == IDX_LAST) begin
                  nxt_r.st = CWL_DONE;
               end else begin
                  nxt_r.idx = r_ff.idx + 2'h1;
                  nxt_r.st  = CWL_REQ;
               end
            end
         end
         CWL_DONE: begin
            // Words frozen until the next reset
            nxt_r.st = CWL_DONE;
         end
         default: begin
            nxt_r.st = CWL_REQ;
         end
      endcase
      // A read taken mid-load answers with the copy held at that edge;
      // software should wait for the load flag before trusting it
      // Table reads see unpacked words from the map base
      if (tbl_req.rd && in_cfg(tbl_req.addr)) begin
         nxt_r.rvalid = 1'b1;
         if (tbl_req.addr == CFG_MAP_BASE) begin
            nxt_r.rdata = r_ff.w1;
         end else if (tbl_req.addr == CFG_MAP_BASE + CFG_STEP) begin
            nxt_r.rdata = r_ff.w2;
         end else if (tbl_req.addr == CFG_MAP_BASE + CFG_STEP + CFG_STEP) begin
            nxt_r.rdata = r_ff.w3;
         end else begin
            nxt_r.rdata = ZERO_WORD;
         end
      end
   end

   // State register; any reset restarts the load
   // Words fall back to the erased pattern while reset is held, so the
   // decode shows the default configuration until word one is loaded
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         r_ff.st     <= CWL_REQ;
         r_ff.idx    <= IDX_W1;
         r_ff.w1     <= ERASED_WORD;
         r_ff.w2     <= ERASED_WORD;
         r_ff.w3     <= ERASED_WORD;
         r_ff.rdata  <= ZERO_WORD;
         r_ff.rvalid <= 1'b0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Flash read port
   // Strobe and address come straight from the state flops: the address is steady
   // from the request cycle, the strobe from the first wait cycle, until the ack is taken
   assign flash_rd      = (r_ff.st == CWL_WAIT);
   assign flash_addr    = word_addr(r_ff.idx);
   assign cfg_loaded    = (r_ff.st == CWL_DONE);
   assign tbl_rdata     = r_ff.rdata;
   assign tbl_rvalid    = r_ff.rvalid;
   assign fetch_blocked = fetch_rd && in_cfg(fetch_addr);

   // Decode word one; erased (all-ones) words give protection off
   // Upper byte is never decoded, so ones written there change nothing
   // Reserved bits 15 and 10 are stored but drive no control
   always_comb begin
      ctrl.test_port_enable         = r_ff.w1[B_TEST];
      ctrl.code_protect_on          = ~r_ff.w1[B_CODE_PROT];
      ctrl.write_protect_on         = ~r_ff.w1[B_GWP];
      ctrl.debug_mode_entry         = ~r_ff.w1[B_OPER];
      ctrl.emulator_pin_pair_select = r_ff.w1[B_EMU_HI:B_EMU_LO];
      ctrl.watchdog_enable          = r_ff.w1[B_WDT_EN];
      // Window only meaningful with watchdog on
      ctrl.window_mode    = ~r_ff.w1[B_WIN_DIS] & r_ff.w1[B_WDT_EN];
      ctrl.prescale_ratio = r_ff.w1[B_PRE] ? PRE_128 : PRE_32;
      ctrl.postscale_ratio = 16'h0001 << r_ff.w1[B_POST_HI:0];
   end

   // The reserved pair code is passed through unchanged; the flag lets the
   // core refuse it instead of silently picking a pin pair
   assign pair_reserved = (r_ff.w1[B_EMU_HI:B_EMU_LO] == PAIR_RSVD);

   // The decode checks from write protect to the pair flag compare against the flash word sampled at
   // the ack rather than against the stored copy, so a swapped or inverted
   // bit anywhere on the load path shows up. Table checks use the word held
   // one cycle earlier, as a read taken mid-load answers with the old copy.

   // Write-protect bit reaches the decode one cycle after word one lands
   a_wp_decode: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && flash_ack && r_ff.idx == IDX_W1)
      |=> (ctrl.write_protect_on == !$past(flash_rdata[B_GWP])))
      else $error("write protect decode wrong");

   // Code-protect bit low protects the whole program memory
   a_cp_decode: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && flash_ack && r_ff.idx == IDX_W1)
      |=> (ctrl.code_protect_on == !$past(flash_rdata[B_CODE_PROT])))
      else $error("code protect decode wrong");

   // Reset-mode bit low sends the core into debug mode
   a_dbg_decode: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && flash_ack && r_ff.idx == IDX_W1)
      |=> (ctrl.debug_mode_entry == !$past(flash_rdata[B_OPER])))
      else $error("debug select wrong");

   // Test port enable follows its bit without inversion
   a_test_port: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && flash_ack && r_ff.idx == IDX_W1)
      |=> (ctrl.test_port_enable == $past(flash_rdata[B_TEST])))
      else $error("test port enable wrong");

   // Watchdog enable follows its bit without inversion
   a_wdt_decode: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && flash_ack && r_ff.idx == IDX_W1)
      |=> (ctrl.watchdog_enable == $past(flash_rdata[B_WDT_EN])))
      else $error("watchdog enable wrong");

   // Reserved pin pair code must be flagged to the core
   a_pair_flag: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && flash_ack && r_ff.idx == IDX_W1)
      |=> (pair_reserved == ($past(flash_rdata[B_EMU_HI:B_EMU_LO]) == PAIR_RSVD)))
      else $error("reserved pair flag wrong");

   // Windowed mode is never shown with the watchdog off
   a_win_needs_en: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      ctrl.window_mode
      |-> ctrl.watchdog_enable)
      else $error("window without watchdog");

   // Prescaler bit low gives the short ratio
   a_pre_ratio: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      !r_ff.w1[B_PRE]
      |-> (ctrl.prescale_ratio == PRE_32))
      else $error("prescaler wrong");

   // Prescaler bit high gives the long ratio
   a_pre_wide: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      r_ff.w1[B_PRE]
      |-> (ctrl.prescale_ratio == PRE_128))
      else $error("long prescaler wrong");

   // Top postscaler code gives the largest ratio
   a_post_ratio: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (r_ff.w1[B_POST_HI:0] == 4'hF)
      |-> (ctrl.postscale_ratio == 16'h8000))
      else $error("postscaler wrong");

   // First request goes to the top word
   a_load_order: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && r_ff.idx == IDX_W1)
      |-> (flash_addr == CFG_TOP))
      else $error("first word address wrong");

   // Second request goes one step below the top
   a_addr_word_two: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && r_ff.idx == IDX_W2)
      |-> (flash_addr == CFG_TOP - CFG_STEP))
      else $error("second word address wrong");

   // Third request goes two steps below the top
   a_addr_word_three: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && r_ff.idx == IDX_W3)
      |-> (flash_addr == CFG_TOP - CFG_STEP - CFG_STEP))
      else $error("third word address wrong");

   // Until word one arrives the defaults stand, never stale contents
   a_reset_erased: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && r_ff.idx == IDX_W1)
      |-> (r_ff.w1 == ERASED_WORD))
      else $error("stale word before reload");

   // Second word lands in its own slot
   a_load_slot: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && flash_ack && r_ff.idx == IDX_W2)
      |=> (r_ff.w2 == $past(flash_rdata)))
      else $error("second word not stored");

   // Last ack ends the load
   a_load_done: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (flash_rd && flash_ack && r_ff.idx == IDX_LAST)
      |=> cfg_loaded)
      else $error("load did not finish");

   // Once loaded, the load flag and the three words stay put until the next reset
   a_frozen_cfg: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      cfg_loaded
      |=> (cfg_loaded && $stable(r_ff.w1) && $stable(r_ff.w2) && $stable(r_ff.w3)))
      else $error("config changed after load");

   // No further flash traffic after the load
   a_idle_no_read: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      cfg_loaded
      |-> !flash_rd)
      else $error("flash read after load");

   // Ordinary accesses into configuration space are blocked
   a_fetch_block: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (fetch_rd && fetch_addr >= CFG_SPACE_LO)
      |-> fetch_blocked)
      else $error("fetch reached config space");

   // Table reads below configuration space get no answer here
   a_tbl_refused: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (tbl_req.rd && tbl_req.addr < CFG_SPACE_LO)
      |=> !tbl_rvalid)
      else $error("table read outside config answered");

   // Table writes are taken but neither answered nor stored
   a_tbl_wr_ignored: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (tbl_req.wr && !tbl_req.rd)
      |=> !tbl_rvalid)
      else $error("table write answered");

   // Map base returns word one as held at the request
   a_tbl_answer: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (tbl_req.rd && tbl_req.addr == CFG_MAP_BASE)
      |=> (tbl_rvalid && tbl_rdata == $past(r_ff.w1)))
      else $error("table read of word one wrong");

   // Next map slot returns word two as held at the request
   a_tbl_word_two: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (tbl_req.rd && tbl_req.addr == CFG_MAP_BASE + CFG_STEP)
      |=> (tbl_rvalid && tbl_rdata == $past(r_ff.w2)))
      else $error("table read of word two wrong");

endmodule : cwl_loader
`default_nettype wire

// [test/cwl_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cwl_flash_model
   import cwl_pkg::*;
#(
   parameter logic [23:0] CFG_TOP = CFG_TOP_LARGE  // Address of word one
) (
   input  wire logic              sys_clk,      // System clock
   input  wire logic              reset_n,      // Active-low reset
   input  wire logic              flash_rd,     // Read strobe from loader
   input  wire logic [ADDR_W-1:0] flash_addr,   // Read address
   input  wire logic [WORD_W-1:0] word_one,     // Stored word one
   input  wire logic [WORD_W-1:0] word_two,     // Stored word two
   input  wire logic [WORD_W-1:0] word_three,   // Stored word three
   input  wire logic [3:0]        wait_cycles,  // Access latency
   output logic                   flash_ack,    // Data valid pulse
   output logic [WORD_W-1:0]      flash_rdata   // Read data
);
   logic [3:0] wait_cnt;  // Cycles spent on the current read

   // Answers after wait_cycles; data churns outside the ack so a stale sample shows
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_cnt    <= 4'h0;
         flash_ack   <= 1'b0;
         flash_rdata <= 24'hA5A5A5;
      end else if (flash_rd && !flash_ack && wait_cnt == wait_cycles) begin
         flash_ack <= 1'b1;
         wait_cnt  <= 4'h0;
         case (flash_addr)  // Three packed words downward from the top
            CFG_TOP:                  flash_rdata <= word_one;
            CFG_TOP - CFG_STEP:       flash_rdata <= word_two;
            CFG_TOP - (CFG_STEP << 1): flash_rdata <= word_three;
            default:                  flash_rdata <= ~flash_rdata;
         endcase
      end else begin
         flash_ack   <= 1'b0;
         flash_rdata <= ~flash_rdata;
         if (flash_rd && !flash_ack) begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule : cwl_flash_model
`default_nettype wire

// [test/config_word_loader_test.sv]
`timescale 1ns/1ps
`default_nettype none
module config_word_loader_test import cwl_pkg::*;;
   logic        sys_clk, reset_n, flash_rd, flash_ack, fetch_rd;  // Clock, reset, strobes
   logic        tbl_rvalid, fetch_blocked, cfg_loaded, pair_reserved;  // Status outputs
   logic [23:0] flash_addr, flash_rdata, fetch_addr, tbl_rdata;  // Address and data
   logic [23:0] w1, w2, w3, w;  // Stored flash words
   logic [3:0]  wait_cycles;    // Flash latency
   cwl_tbl_s    tbl_req;        // Table access
   cwl_ctrl_s   ctrl;           // Decoded controls
   int          n_errors, comparisons, cycles;  // Bookkeeping
   // Word one low halves: bit 15 zero, bit 10 one in the first four, last entry is an all-zero word
   logic [15:0] lows [5] = '{16'h7FFF, 16'h4680, 16'h155F, 16'h2C0A, 16'h0000};

   cwl_loader #(.CFG_TOP(CFG_TOP_SMALL)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_ack(flash_ack),
      .flash_rdata(flash_rdata), .tbl_req(tbl_req), .fetch_rd(fetch_rd),
      .fetch_addr(fetch_addr), .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid),
      .fetch_blocked(fetch_blocked), .cfg_loaded(cfg_loaded), .ctrl(ctrl),
      .pair_reserved(pair_reserved));
   cwl_flash_model #(.CFG_TOP(CFG_TOP_SMALL)) flash (.sys_clk(sys_clk), .reset_n(reset_n),
      .flash_rd(flash_rd), .flash_addr(flash_addr), .word_one(w1), .word_two(w2),
      .word_three(w3), .wait_cycles(wait_cycles), .flash_ack(flash_ack),
      .flash_rdata(flash_rdata));

   // Expected controls worked out bit by bit from a stored word
   function automatic cwl_ctrl_s exp_ctrl(input logic [23:0] v);
      cwl_ctrl_s c;
      c.test_port_enable         = v[14];
      c.code_protect_on          = !v[13];
      c.write_protect_on         = !v[12];
      c.debug_mode_entry         = !v[11];
      c.emulator_pin_pair_select = v[9:8];
      c.watchdog_enable          = v[7];
      c.window_mode              = v[7] && !v[6];
      c.prescale_ratio           = v[4] ? PRE_128 : PRE_32;
      c.postscale_ratio          = 16'h0001 << v[3:0];
      return c;
   endfunction : exp_ctrl

   // Counts a comparison and reports a mismatch at once
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
      end
   endtask : check

   // Holds reset with new flash contents, then waits a bounded time for the load
   task automatic do_reset(input logic [23:0] a, b, c, input logic [3:0] lat);
      @(posedge sys_clk);
      reset_n     <= 1'b0;
      w1          <= a;
      w2          <= b;
      w3          <= c;
      wait_cycles <= lat;
      repeat (10) @(posedge sys_clk);
      check(cfg_loaded, 0);
      check(ctrl, exp_ctrl(ERASED_WORD));
      reset_n <= 1'b1;
      for (int k = 0; k < 200 && cfg_loaded !== 1'b1; k++) @(posedge sys_clk);
      #1 check(cfg_loaded, 1);
   endtask : do_reset

   // One table access; answer looked at in the single cycle it stands
   task automatic tbl(input logic wr, input logic [23:0] a, input logic vld,
                      input logic [23:0] d);
      @(posedge sys_clk);
      tbl_req <= '{rd: !wr, wr: wr, addr: a};
      @(posedge sys_clk);
      tbl_req <= '0;
      #1 check(tbl_rvalid, vld);
      if (vld) check(tbl_rdata, d);
   endtask : tbl

   // Ordinary access probe against the configuration space
   task automatic probe(input logic [23:0] a, input logic exp);
      @(posedge sys_clk);
      fetch_rd   <= 1'b1;
      fetch_addr <= a;
      #1 check(fetch_blocked, exp);
   endtask : probe

   // Prints the counts and the verdict, then stops
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         end_of_test();
      end
   end

   // Each pass reloads through a fresh reset, alternating prompt and slow flash
   initial begin
      reset_n = 1'b0; tbl_req = '0; fetch_rd = 1'b0; fetch_addr = 24'h000000;
      w1 = ERASED_WORD; w2 = ERASED_WORD; w3 = ERASED_WORD; wait_cycles = 4'h0;
      n_errors = 0; comparisons = 0; cycles = 0;
      for (int i = 0; i < 5; i++) begin
         w = (i == 4) ? ZERO_WORD : {8'hFF, lows[i]};
         do_reset(w, (i == 4) ? ZERO_WORD : 24'hFF1230 + 24'(i),
                  (i == 4) ? ZERO_WORD : 24'hFF5670 + 24'(i), (i % 2) ? 4'h3 : 4'h0);
         check(ctrl, exp_ctrl(w));
         check(pair_reserved, w[9:8] == PAIR_RSVD);
         tbl(1'b0, CFG_MAP_BASE, 1'b1, w);
         tbl(1'b0, CFG_MAP_BASE + 24'h000002, 1'b1, w2);
         tbl(1'b0, CFG_MAP_BASE + 24'h000004, 1'b1, w3);
         tbl(1'b0, CFG_MAP_BASE + 24'h000006, 1'b1, ZERO_WORD);
         tbl(1'b0, 24'h7FFFFE, 1'b0, ZERO_WORD);
         tbl(1'b1, CFG_MAP_BASE, 1'b0, ZERO_WORD);
         probe(24'h7FFFFF, 1'b0);
         probe(CFG_SPACE_LO, 1'b1);
         check(ctrl, exp_ctrl(w));
         $display("test %0d done", i);
      end
      end_of_test();
   end
endmodule : config_word_loader_test
`default_nettype wire
